// [bit_call_cmov_cmp_decode.sv]
/*
 * Decode and one-cycle execute for: test_and_set_bit with immediate
 * index, near/far calls, accumulator widen and sign spread, carry and
 * direction flag ops, flush_line, the sixteen conditional moves and
 * compare_op with immediates. Owns the six status flags.
 * Assumes fetch presents one fully decoded instruction per valid
 * cycle, with the reg/mem operand already read by the operand path.
 */
`timescale 1ns/10ps
`include "bit_call_cmov_cmp_cfg.svh"

module bit_call_cmov_cmp_decode
(
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Decoded instruction from fetch
  input wire logic i_valid,
  input wire logic i_two_byte,
  input wire logic [7:0] i_opcode,
  input wire logic [2:0] i_modrm_reg,
  input wire bit_call_cmov_cmp_pkg::opsize_t i_opsize,
  input wire logic [63:0] i_imm,
  input wire logic [63:0] i_next_ip,
  input wire logic [63:0] i_eff_addr,
  // Operands
  input wire logic [63:0] i_acc,
  input wire logic [63:0] i_rm_data,
  // Flag load from other execute slices
  input wire logic i_flag_load,
  input wire logic [5:0] i_flag_val,
  // Completion
  output logic o_done,
  output logic o_illegal,
  // Status flags
  output logic o_carry_flag,
  output logic o_zero_flag,
  output logic o_sign_flag,
  output logic o_overflow_flag,
  output logic o_parity_flag,
  output logic o_direction_flag,
  // Register and memory writes
  output logic o_rm_wr,
  output logic [63:0] o_rm_data,
  output logic o_reg_wr,
  output logic [63:0] o_reg_data,
  output logic o_acc_wr,
  output logic [63:0] o_acc_data,
  output logic o_ext_wr,
  output logic [63:0] o_ext_data,
  // Control transfer
  output logic o_jump,
  output logic o_jump_far,
  output logic [15:0] o_jump_sel,
  output logic [63:0] o_jump_target,
  output logic [63:0] o_ret_ip,
  // Cache maintenance
  output logic o_flush,
  output logic [63:0] o_flush_addr
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Keep only the bits of the given operand size
  function automatic logic [63:0] fit(bit_call_cmov_cmp_pkg::opsize_t sz, logic [63:0] v);
    logic [63:0] r;
    r = v;
    case (sz)
      bit_call_cmov_cmp_pkg::SZ8: r = {56'h0, v[7:0]};
      bit_call_cmov_cmp_pkg::SZ16: r = {48'h0, v[15:0]};
      bit_call_cmov_cmp_pkg::SZ32: r = {32'h0, v[31:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  // Most significant bit at the given size
  function automatic logic top_bit(bit_call_cmov_cmp_pkg::opsize_t sz, logic [63:0] v);
    logic r;
    r = v[63];
    case (sz)
      bit_call_cmov_cmp_pkg::SZ8: r = v[7];
      bit_call_cmov_cmp_pkg::SZ16: r = v[15];
      bit_call_cmov_cmp_pkg::SZ32: r = v[31];
      default: r = v[63];
    endcase
    return r;
  endfunction

  // Sign-extend a value of the given size to 64 bits
  function automatic logic [63:0] sext(bit_call_cmov_cmp_pkg::opsize_t sz, logic [63:0] v);
    logic [63:0] r;
    r = v;
    case (sz)
      bit_call_cmov_cmp_pkg::SZ8: r = {{56{v[7]}}, v[7:0]};
      bit_call_cmov_cmp_pkg::SZ16: r = {{48{v[15]}}, v[15:0]};
      bit_call_cmov_cmp_pkg::SZ32: r = {{32{v[31]}}, v[31:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  // Half of the operand size, source of an in-place widen
  function automatic bit_call_cmov_cmp_pkg::opsize_t half(bit_call_cmov_cmp_pkg::opsize_t sz);
    bit_call_cmov_cmp_pkg::opsize_t r;
    r = bit_call_cmov_cmp_pkg::SZ32;
    case (sz)
      bit_call_cmov_cmp_pkg::SZ16: r = bit_call_cmov_cmp_pkg::SZ8;
      bit_call_cmov_cmp_pkg::SZ32: r = bit_call_cmov_cmp_pkg::SZ16;
      default: r = bit_call_cmov_cmp_pkg::SZ32;
    endcase
    return r;
  endfunction

  // Immediates and offsets never exceed 32 bits in this slice
  function automatic bit_call_cmov_cmp_pkg::opsize_t imm_sz(bit_call_cmov_cmp_pkg::opsize_t sz);
    return (sz == bit_call_cmov_cmp_pkg::SZ16) ? bit_call_cmov_cmp_pkg::SZ16
                                               : bit_call_cmov_cmp_pkg::SZ32;
  endfunction

  // Condition evaluation for the conditional-move range
  function automatic logic cond_true(logic [3:0] cc, logic cf, logic zf, logic sf,
                                     logic of, logic pf);
    logic r;
    r = 1'b0;
    case (cc[3:1])
      3'h0: r = of;
      3'h1: r = cf;
      3'h2: r = zf;
      3'h3: r = cf | zf;
      3'h4: r = sf;
      3'h5: r = pf;
      3'h6: r = sf ^ of;
      default: r = zf | (sf ^ of);
    endcase
    // Odd codes are the exact complement, so 7 and F need both flags
    return r ^ cc[0];
  endfunction

  // ****************************************
  // Opcode decode
  // ****************************************
  wire logic one_byte = i_valid & ~i_two_byte;
  wire logic two_byte = i_valid & i_two_byte;
  wire bit_call_cmov_cmp_pkg::opsize_t sz = i_opsize;
  wire bit_call_cmov_cmp_pkg::opsize_t isz = imm_sz(i_opsize);
  wire logic is_bts = two_byte & (i_opcode == `OPC_BIT_IMM) & (i_modrm_reg == `REG_BTS);
  wire logic is_flush = two_byte & (i_opcode == `OPC_FENCE_GRP)
                        & (i_modrm_reg == `REG_FLUSH);
  wire logic is_cmov = two_byte & (i_opcode[7:4] == `OPC_CMOV_HI);
  wire logic is_call_rel = one_byte & (i_opcode == `OPC_CALL_REL);
  wire logic is_call_ind = one_byte & (i_opcode == `OPC_GRP_FF)
                           & (i_modrm_reg == `REG_CALL_NEAR);
  wire logic is_far_ind = one_byte & (i_opcode == `OPC_GRP_FF)
                          & (i_modrm_reg == `REG_CALL_FAR);
  wire logic is_far_dir = one_byte & (i_opcode == `OPC_CALL_FAR);
  wire logic is_widen = one_byte & (i_opcode == `OPC_WIDEN);
  wire logic is_spread = one_byte & (i_opcode == `OPC_SPREAD);
  wire logic is_clc = one_byte & (i_opcode == `OPC_CLR_CARRY);
  wire logic is_cld = one_byte & (i_opcode == `OPC_CLR_DIR);
  wire logic is_cmc = one_byte & (i_opcode == `OPC_TGL_CARRY);
  wire logic is_cmp_acc8 = one_byte & (i_opcode == `OPC_CMP_ACC8);
  wire logic is_cmp_acc = one_byte & (i_opcode == `OPC_CMP_ACC);
  wire logic grp_cmp = one_byte & (i_modrm_reg == `REG_CMP);
  wire logic is_cmp_rm8 = grp_cmp & (i_opcode == `OPC_IMM_GRP8);
  wire logic is_cmp_rm = grp_cmp & (i_opcode == `OPC_IMM_GRP);
  wire logic is_cmp_rmsx = grp_cmp & (i_opcode == `OPC_IMM_GRP_SX);
  wire logic is_cmp = is_cmp_acc8 | is_cmp_acc | is_cmp_rm8 | is_cmp_rm | is_cmp_rmsx;
  wire logic is_call = is_call_rel | is_call_ind | is_far_ind | is_far_dir;
  wire logic is_far = is_far_ind | is_far_dir;
  // Anything not in this slice is flagged so another slice can claim it
  wire logic known = is_bts | is_flush | is_cmov | is_call | is_widen | is_spread
                     | is_clc | is_cld | is_cmc | is_cmp;

  // ****************************************
  // test_and_set_bit datapath
  // ****************************************
  // Index wraps at operand width for 16, 32 and 64 bits, as with a register operand; byte size keeps six index bits
  wire logic [5:0] bit_idx = (sz == bit_call_cmov_cmp_pkg::SZ16) ? {2'h0, i_imm[3:0]} :
                             (sz == bit_call_cmov_cmp_pkg::SZ32) ? {1'h0, i_imm[4:0]} :
                             i_imm[5:0];
  wire logic bts_old = i_rm_data[bit_idx];
  wire logic [63:0] bts_data = fit(sz, i_rm_data | (64'h0000000000000001 << bit_idx));

  // ****************************************
  // Call targets
  // ****************************************
  wire logic [63:0] rel_target = fit(sz, i_next_ip + sext(isz, i_imm));
  wire logic [63:0] ind_target = fit(sz, i_rm_data);
  // Far pointer: embedded for direct, memory operand for indirect
  wire logic [63:0] far_ptr = is_far_dir ? i_imm : i_rm_data;
  wire logic [63:0] far_off = fit(isz, far_ptr);
  wire logic [15:0] far_sel = (isz == bit_call_cmov_cmp_pkg::SZ16) ? far_ptr[31:16]
                                                                   : far_ptr[47:32];
  wire logic [63:0] call_target = is_call_rel ? rel_target :
                                  is_call_ind ? ind_target : far_off;

  // ****************************************
  // Accumulator widen and spread
  // ****************************************
  wire logic [63:0] widen_data = fit(sz, sext(half(sz), i_acc));
  wire logic [63:0] spread_data = fit(sz, {64{top_bit(sz, i_acc)}});

  // ****************************************
  // Conditional move
  // ****************************************
  wire logic cmov_take = is_cmov & cond_true(i_opcode[3:0], o_carry_flag, o_zero_flag,
                                             o_sign_flag, o_overflow_flag,
                                             o_parity_flag);

  // ****************************************
  // Compare datapath
  // ****************************************
  // Byte forms fix the size at one byte whatever the prefix says
  wire bit_call_cmov_cmp_pkg::opsize_t cmp_sz = (is_cmp_acc8 | is_cmp_rm8)
                                                ? bit_call_cmov_cmp_pkg::SZ8 : sz;
  wire logic [63:0] cmp_lhs = fit(cmp_sz, (is_cmp_acc8 | is_cmp_acc) ? i_acc : i_rm_data);
  wire logic [63:0] cmp_imm = (is_cmp_acc8 | is_cmp_rm8) ? i_imm :
                              is_cmp_rmsx ? sext(bit_call_cmov_cmp_pkg::SZ8, i_imm) :
                              sext(isz, i_imm);
  wire logic [63:0] cmp_rhs = fit(cmp_sz, cmp_imm);
  // Difference is only used for flags and then dropped
  wire logic [63:0] cmp_res = fit(cmp_sz, cmp_lhs - cmp_rhs);
  wire logic cmp_lsb = top_bit(cmp_sz, cmp_lhs);
  wire logic cmp_rsb = top_bit(cmp_sz, cmp_rhs);
  wire logic cmp_dsb = top_bit(cmp_sz, cmp_res);
  wire logic cmp_cf = cmp_lhs < cmp_rhs;
  wire logic cmp_of = (cmp_lsb != cmp_rsb) & (cmp_dsb != cmp_lsb);
  wire logic cmp_pf = ~^cmp_res[7:0];

  // ****************************************
  // Next flag values
  // ****************************************
  wire logic fire = i_ce & i_valid;
  wire logic carry_d = is_cmp ? cmp_cf :
                       is_bts ? bts_old :
                       is_clc ? 1'b0 :
                       is_cmc ? ~o_carry_flag :
                       o_carry_flag;
  wire logic direction_d = is_cld ? 1'b0 : o_direction_flag;

  // ****************************************
  // Flag registers
  // ****************************************
  // Own instructions win over a load from another slice in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      // Flags live in the output flops, so they leave straight from a register
      o_carry_flag <= `FLAG_RST;
      o_zero_flag <= `FLAG_RST;
      o_sign_flag <= `FLAG_RST;
      o_overflow_flag <= `FLAG_RST;
      o_parity_flag <= `FLAG_RST;
      o_direction_flag <= `FLAG_RST;
    end
    else if (fire & known)
    begin
      o_carry_flag <= carry_d;
      o_direction_flag <= direction_d;
      if (is_cmp)
      begin
        o_zero_flag <= (cmp_res == `DATA_RST);
        o_sign_flag <= cmp_dsb;
        o_overflow_flag <= cmp_of;
        o_parity_flag <= cmp_pf;
      end
    end
    else if (i_ce & i_flag_load)
    begin
      // External flag load for instructions outside this slice
      {o_carry_flag, o_zero_flag, o_sign_flag, o_overflow_flag, o_parity_flag,
       o_direction_flag} <= i_flag_val;
    end
  end

  // ****************************************
  // Result strobes, one cycle per instruction
  // ****************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_rm_wr <= 1'b0;
      o_reg_wr <= 1'b0;
      o_acc_wr <= 1'b0;
      o_ext_wr <= 1'b0;
      o_jump <= 1'b0;
      o_jump_far <= 1'b0;
      o_flush <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= i_valid;
      o_illegal <= i_valid & ~known;
      o_rm_wr <= is_bts;
      o_reg_wr <= cmov_take;
      o_acc_wr <= is_widen;
      o_ext_wr <= is_spread;
      o_jump <= is_call;
      o_jump_far <= is_far;
      o_flush <= is_flush;
    end
  end

  // ****************************************
  // Result data, held until the next instruction
  // ****************************************
  // Data only moves on valid cycles so it stays stable for the writer
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_rm_data <= `DATA_RST;
      o_reg_data <= `DATA_RST;
      o_acc_data <= `DATA_RST;
      o_ext_data <= `DATA_RST;
      o_jump_sel <= `SEL_RST;
      o_jump_target <= `DATA_RST;
      o_ret_ip <= `DATA_RST;
      o_flush_addr <= `DATA_RST;
    end
    else if (fire)
    begin
      o_rm_data <= bts_data;
      o_reg_data <= fit(sz, i_rm_data);
      o_acc_data <= widen_data;
      o_ext_data <= spread_data;
      o_jump_sel <= is_far ? far_sel : `SEL_RST;
      o_jump_target <= call_target;
      o_ret_ip <= i_next_ip;
      o_flush_addr <= i_eff_addr;
    end
  end

endmodule

// [bit_call_cmov_cmp_cfg.svh]
/*
 * Encodings and reset values for the bit-set, call, widen, flag,
 * flush, conditional-move and compare slice of the execute stage.
 * Assumes it is included by its bare name before any use.
 */
`ifndef BIT_CALL_CMOV_CMP_CFG_SVH
`define BIT_CALL_CMOV_CMP_CFG_SVH

// ****************************************
// Opcode bytes
// ****************************************
`define OPC_BIT_IMM 8'hBA
`define OPC_CALL_REL 8'hE8
`define OPC_GRP_FF 8'hFF
`define OPC_CALL_FAR 8'h9A
`define OPC_WIDEN 8'h98
`define OPC_SPREAD 8'h99
`define OPC_CLR_CARRY 8'hF8
`define OPC_CLR_DIR 8'hFC
`define OPC_TGL_CARRY 8'hF5
`define OPC_FENCE_GRP 8'hAE
`define OPC_CMOV_HI 4'h4
`define OPC_CMP_ACC8 8'h3C
`define OPC_CMP_ACC 8'h3D
`define OPC_IMM_GRP8 8'h80
`define OPC_IMM_GRP 8'h81
`define OPC_IMM_GRP_SX 8'h83

// ****************************************
// ModRM reg field selectors
// ****************************************
`define REG_BTS 3'h5
`define REG_CALL_NEAR 3'h2
`define REG_CALL_FAR 3'h3
`define REG_FLUSH 3'h7
`define REG_CMP 3'h7

// ****************************************
// Reset values
// ****************************************
`define FLAG_RST 1'h0
`define DATA_RST 64'h0000000000000000
`define SEL_RST 16'h0000

`endif

// [bit_call_cmov_cmp_pkg.sv]
/*
 * Types shared by the bit-set, call, flag and compare execute slice.
 * Assumes the fetch stage encodes operand size with opsize_t.
 */
package bit_call_cmov_cmp_pkg;

  // Effective operand size of the instruction
  typedef enum logic [1:0]
  {
    SZ8,
    SZ16,
    SZ32,
    SZ64
  } opsize_t;

endpackage

// [bit_call_cmov_cmp_props.sv]
/* Concurrent checks on the decode slice, bound to its ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module bit_call_cmov_cmp_props
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Instruction in
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic i_two_byte,
  input wire logic [7:0] i_opcode,
  input wire logic [2:0] i_modrm_reg,
  input wire bit_call_cmov_cmp_pkg::opsize_t i_opsize,
  input wire logic [63:0] i_imm,
  input wire logic [63:0] i_next_ip,
  input wire logic [63:0] i_eff_addr,
  input wire logic [63:0] i_acc,
  input wire logic [63:0] i_rm_data,
  // Results out
  input wire logic o_done,
  input wire logic o_carry_flag,
  input wire logic o_zero_flag,
  input wire logic o_sign_flag,
  input wire logic o_overflow_flag,
  input wire logic o_parity_flag,
  input wire logic o_direction_flag,
  input wire logic o_rm_wr,
  input wire logic [63:0] o_rm_data,
  input wire logic o_reg_wr,
  input wire logic o_jump,
  input wire logic o_jump_far,
  input wire logic [63:0] o_ret_ip,
  input wire logic o_flush,
  input wire logic [63:0] o_flush_addr
);
  // ********
  // Helpers
  // ********
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic [63:0] bts_q; // Operand with chosen bit set
  logic bit_q; // Chosen bit before the set
  logic [7:0] cnd; // Condition of each even code
  logic hit; // Condition of the presented code
  assign cnd = {o_zero_flag | (o_sign_flag ^ o_overflow_flag), o_sign_flag ^ o_overflow_flag,
                o_parity_flag, o_sign_flag, o_carry_flag | o_zero_flag, o_zero_flag,
                o_carry_flag, o_overflow_flag};
  assign hit = cnd[i_opcode[3:1]] ^ i_opcode[0];
  // Sampled every edge, so only read one edge after a 64-bit bit-set
  always_ff @(posedge i_core_clk)
  begin
    bts_q <= i_rm_data | (64'h1 << i_imm[5:0]);
    bit_q <= i_rm_data[i_imm[5:0]];
  end
  // ********
  // Sequences and checks
  // ********
  sequence s_op(logic [7:0] op, logic tw);
    i_ce && i_valid && i_two_byte == tw && i_opcode == op;
  endsequence
  sequence s_cmov;
    i_ce && i_valid && i_two_byte && i_opcode[7:4] == 4'h4;
  endsequence
  chk_clc_clears: assert property (s_op(8'hF8, 1'b0) |=> !o_carry_flag)
    else $error("carry not cleared");
  chk_cld_clears: assert property (s_op(8'hFC, 1'b0) |=> !o_direction_flag)
    else $error("direction not cleared");
  chk_cmc_flips: assert property (s_op(8'hF5, 1'b0) |=>
    o_carry_flag != $past(o_carry_flag))
    else $error("carry not toggled");
  chk_bts_result: assert property (s_op(8'hBA, 1'b1) ##0 (i_modrm_reg == 3'h5 &&
    i_opsize == bit_call_cmov_cmp_pkg::SZ64) |=>
    o_rm_wr && o_rm_data == bts_q && o_carry_flag == bit_q)
    else $error("bit set wrong");
  chk_cmov_taken: assert property (s_cmov ##0 hit |=> o_reg_wr)
    else $error("move missed");
  chk_cmov_skip: assert property (s_cmov ##0 !hit |=> !o_reg_wr)
    else $error("move not suppressed");
  chk_call_ret: assert property (s_op(8'hE8, 1'b0) |=> o_jump && !o_jump_far &&
    o_ret_ip == $past(i_next_ip))
    else $error("near call wrong");
  chk_flush_addr: assert property (s_op(8'hAE, 1'b1) ##0 i_modrm_reg == 3'h7 |=>
    o_flush && o_flush_addr == $past(i_eff_addr))
    else $error("flush wrong");
  chk_cmp_no_write: assert property (s_op(8'h3C, 1'b0) |=>
    o_done && !o_rm_wr && !o_reg_wr && !o_jump)
    else $error("compare wrote");
  chk_cmp_equal: assert property (s_op(8'h3C, 1'b0) ##0 i_acc[7:0] == i_imm[7:0] |=>
    o_zero_flag && !o_carry_flag)
    else $error("equal compare flags");
endmodule
bind bit_call_cmov_cmp_decode bit_call_cmov_cmp_props u_bit_call_cmov_cmp_props (.*);

// [operand_path_model.sv]
/* Operand path model: eight-word store read by address, written back.
   Assumes write-back strobe comes one edge after the address was taken. */
`timescale 1ns/10ps
module operand_path_model
(
  // Clock
  input wire logic i_core_clk,
  // Access from the slice
  input wire logic [63:0] i_addr,
  input wire logic i_wr,
  input wire logic [63:0] i_wdata,
  // Operand to the slice
  output logic [63:0] o_rdata
);
  logic [63:0] mem_q [8]; // Small store, low address bits only
  logic [2:0] addr_q; // Address of the instruction just taken
  initial
  begin
    for (int k = 0; k < 8; k++)
      mem_q[k] = 64'h0123456789ABCDEF ^ (64'h1111 * k);
  end
  assign o_rdata = mem_q[i_addr[2:0]];
  // Write back lands where the bit-set read from
  always @(posedge i_core_clk)
  begin
    addr_q <= i_addr[2:0];
    if (i_wr)
      mem_q[addr_q] <= i_wdata;
  end
endmodule

// [tb_top.sv]
/* Self-checking bench for the decode slice and the operand path model.
   Assumes package, design and checker are compiled first. */
`timescale 1ns/10ps
module tb_top;
  // ********
  // Signals
  // ********
  localparam bit_call_cmov_cmp_pkg::opsize_t s8 = bit_call_cmov_cmp_pkg::SZ8;
  localparam bit_call_cmov_cmp_pkg::opsize_t s16 = bit_call_cmov_cmp_pkg::SZ16;
  localparam bit_call_cmov_cmp_pkg::opsize_t s32 = bit_call_cmov_cmp_pkg::SZ32;
  localparam bit_call_cmov_cmp_pkg::opsize_t s64 = bit_call_cmov_cmp_pkg::SZ64;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_valid = 1'b0;
  logic i_two_byte = 1'b0, i_flag_load = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [2:0] i_modrm_reg = 3'h0;
  logic [5:0] i_flag_val = 6'h00;
  bit_call_cmov_cmp_pkg::opsize_t i_opsize = bit_call_cmov_cmp_pkg::SZ64;
  logic [63:0] i_imm = 64'h0, i_next_ip = 64'h0, i_eff_addr = 64'h0, i_acc = 64'h0;
  logic [63:0] i_rm_data;
  logic o_done, o_illegal, o_carry_flag, o_zero_flag, o_sign_flag, o_overflow_flag;
  logic o_parity_flag, o_direction_flag, o_rm_wr, o_reg_wr, o_acc_wr, o_ext_wr;
  logic o_jump, o_jump_far, o_flush;
  logic [15:0] o_jump_sel;
  logic [63:0] o_rm_data, o_reg_data, o_acc_data, o_ext_data, o_jump_target, o_ret_ip;
  logic [63:0] o_flush_addr;
  int n_errors = 0;
  int tests_run = 0;
  int w, f;
  logic [31:0] seed = 32'h00000020; // Fixed start keeps runs repeatable
  logic [63:0] acc_n = 64'h0, ea_n = 64'h0, ip_n = 64'h0, rm_s, im, a, b, d, m;
  logic [5:0] fl;
  logic [7:0] ix;
  bit_call_cmov_cmp_pkg::opsize_t sz;
  always #5 i_core_clk = ~i_core_clk;
  bit_call_cmov_cmp_decode u_bit_call_cmov_cmp_decode (.*);
  operand_path_model u_operand_path_model (.i_core_clk(i_core_clk), .i_addr(i_eff_addr),
    .i_wr(o_rm_wr), .i_wdata(o_rm_data), .o_rdata(i_rm_data));
  // ********
  // Helpers
  // ********
  function automatic logic [63:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {seed, ~seed};
  endfunction
  function automatic logic [63:0] msk(input bit_call_cmov_cmp_pkg::opsize_t s);
    return (s == s64) ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << (8 << s)) - 64'h1;
  endfunction
  // Flags packed as carry, zero, sign, overflow, parity, direction
  function automatic logic cnd(input logic [3:0] cc, input logic [5:0] v);
    logic [7:0] t;
    t = {v[4] | (v[3] ^ v[2]), v[3] ^ v[2], v[1], v[3], v[5] | v[4], v[4], v[5], v[2]};
    return t[cc[3:1]] ^ cc[0];
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One instruction, taken at the second edge, results read just after it
  task automatic go(input logic [7:0] op, input logic tw, input logic [2:0] rg,
                    input bit_call_cmov_cmp_pkg::opsize_t s, input logic [63:0] iv);
    @(posedge i_core_clk);
    i_valid <= 1'b1;
    i_opcode <= op;
    i_two_byte <= tw;
    i_modrm_reg <= rg;
    i_opsize <= s;
    i_imm <= iv;
    i_acc <= acc_n;
    i_eff_addr <= ea_n;
    i_next_ip <= ip_n;
    #1;
    rm_s = i_rm_data;
    @(posedge i_core_clk);
    i_valid <= 1'b0;
    #1;
  endtask
  task automatic ldf(input logic [5:0] v);
    @(posedge i_core_clk);
    i_flag_load <= 1'b1;
    i_flag_val <= v;
    @(posedge i_core_clk);
    i_flag_load <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("counts: tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: a hang counts as a failure
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    n_errors++;
    give_verdict();
  end
  // ********
  // Scenarios
  // ********
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk({o_done, o_carry_flag, o_jump, o_rm_wr}, 64'h0);
    $display("test reset ended");
    ldf(6'h3F);
    go(8'hF8, 1'b0, 3'h0, s32, 64'h0);
    chk({o_carry_flag, o_zero_flag}, 64'h1);
    go(8'hF5, 1'b0, 3'h0, s32, 64'h0);
    chk(o_carry_flag, 1'b1);
    go(8'hFC, 1'b0, 3'h0, s32, 64'h0);
    chk(o_direction_flag, 1'b0);
    // Clock enable low: toggle request must wait, nothing moves
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    i_valid <= 1'b1;
    i_opcode <= 8'hF5;
    repeat (3) @(posedge i_core_clk);
    #1;
    chk({o_done, o_carry_flag}, 64'h1);
    // Enable returns on an edge, so the held request is taken one edge later
    @(posedge i_core_clk);
    i_ce <= 1'b1;
    @(posedge i_core_clk);
    i_valid <= 1'b0;
    #1;
    chk({o_done, o_carry_flag}, 64'h2);
    $display("test flags ended");
    // Bit set twice on one word: second sees the written-back bit
    for (int j = 1; j < 4; j++)
    begin
      sz = bit_call_cmov_cmp_pkg::opsize_t'(j);
      ea_n = 64'(j);
      im = rnd() & 64'hFF;
      for (int r = 0; r < 2; r++)
      begin
        go(8'hBA, 1'b1, 3'h5, sz, im);
        ix = 8'(im[7:0] % (8 << j));
        chk(o_rm_wr, 1'b1);
        chk(o_rm_data, (rm_s | (64'h1 << ix)) & msk(sz));
        chk(o_carry_flag, rm_s[ix]);
      end
    end
    $display("test bitset ended");
    for (int k = 0; k < 32; k++)
    begin
      fl = 6'(rnd());
      ea_n = rnd();
      sz = bit_call_cmov_cmp_pkg::opsize_t'(1 + k % 3);
      ldf(fl);
      go({4'h4, 4'(k)}, 1'b1, 3'h0, sz, 64'h0);
      if (k % 16 < 8)
        chk(o_reg_wr, cnd(4'(k), fl));
      else
        chk(o_reg_wr, cnd(4'(k), fl));
      if (cnd(4'(k), fl))
        chk(o_reg_data, rm_s & msk(sz));
    end
    $display("test cmov ended");
    ip_n = rnd();
    im = rnd() & 64'hFFFFFFFF;
    go(8'hE8, 1'b0, 3'h0, s32, im);
    chk({o_jump, o_jump_far}, 64'h2);
    chk(o_ret_ip, ip_n);
    chk(o_jump_target, (ip_n + {{32{im[31]}}, im[31:0]}) & msk(s32));
    go(8'hE8, 1'b0, 3'h0, s16, im & 64'hFFFF);
    chk(o_jump_target, (ip_n + {{48{im[15]}}, im[15:0]}) & msk(s16));
    go(8'hFF, 1'b0, 3'h2, s64, 64'h0);
    chk({o_jump, o_jump_far}, 64'h2);
    chk(o_jump_target, rm_s);
    go(8'h9A, 1'b0, 3'h0, s16, im);
    chk({o_jump_far, o_jump_sel}, {1'b1, im[31:16]});
    chk(o_jump_target, 64'(im[15:0]));
    go(8'hFF, 1'b0, 3'h3, s32, 64'h0);
    chk({o_jump_far, o_jump_sel}, {1'b1, rm_s[47:32]});
    chk(o_jump_target, 64'(rm_s[31:0]));
    $display("test calls ended");
    acc_n = rnd() | 64'h0000000080000080;
    go(8'h98, 1'b0, 3'h0, s64, 64'h0);
    chk({o_acc_wr, o_acc_data[63:32]}, {1'b1, {32{acc_n[31]}}});
    chk(o_acc_data[31:0], acc_n[31:0]);
    go(8'h98, 1'b0, 3'h0, s16, 64'h0);
    chk(o_acc_data[15:0], {{8{acc_n[7]}}, acc_n[7:0]});
    go(8'h99, 1'b0, 3'h0, s32, 64'h0);
    chk(o_ext_wr, 1'b1);
    chk(o_ext_data, {32'h0, {32{acc_n[31]}}});
    ea_n = rnd();
    go(8'hAE, 1'b1, 3'h7, s64, 64'h0);
    chk(o_flush, 1'b1);
    chk(o_flush_addr, ea_n);
    go(8'h37, 1'b0, 3'h0, s64, 64'h0);
    chk({o_illegal, o_rm_wr, o_jump}, 64'h4);
    $display("test misc ended");
    // Compare forms; first pass forces equal operands
    for (int k = 0; k < 10; k++)
    begin
      f = k % 5;
      acc_n = rnd();
      ea_n = rnd();
      im = (k == 0) ? acc_n : rnd();
      im = im & ((f == 1) ? 64'hFFFFFFFF : (f == 2) ? 64'hFFFF : 64'hFF);
      sz = (f == 2) ? s16 : (f == 1 || f == 3) ? s64 : s8;
      go((f == 0) ? 8'h3C : (f == 1) ? 8'h3D : (f == 2) ? 8'h81 : (f == 3) ? 8'h83 : 8'h80,
         1'b0, (f < 2) ? 3'h0 : 3'h7, sz, im);
      b = (f == 1) ? {{32{im[31]}}, im[31:0]} : (f == 3) ? {{56{im[7]}}, im[7:0]} : im;
      m = msk(sz);
      w = 8 << sz;
      a = ((f < 2) ? acc_n : rm_s) & m;
      b = b & m;
      d = (a - b) & m;
      chk({o_carry_flag, o_zero_flag}, {a < b, d == 64'h0});
      chk({o_sign_flag, o_overflow_flag},
          {d[w-1], a[w-1] != b[w-1] && d[w-1] != a[w-1]});
      chk(o_parity_flag, ~^d[7:0]);
      chk({o_done, o_rm_wr, o_reg_wr, o_acc_wr, o_jump}, 64'h10);
    end
    $display("test compare ended");
    give_verdict();
  end
endmodule
